// *** core/fcw_top.sv ***
// Frequency-change watchdog with reset pulse, alarm and frequency fallback
// Notes on behaviour
// - Apply new frequency, then start timer
// - Clearing timeout keeps new frequency, no reset
// - First expiry: reset pulse, alarm, restart
// - Later expiry also restores fallback frequency
// - Expiry sequence repeats until timeout cleared
// - Zero timeout stops timer, clears alarm
// - Timeout code n means n seconds
// - Revert bit picks strap or earlier setting
// - Shared pin drives reset only when selected
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module fcw_top
    import fcw_pkg::*;
#(
    parameter int unsigned SEC_CYCLES_P = fcw_pkg::SEC_CYCLES   // Cycles in one second
) (
    // Clock, reset and enable
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    // Avalon-MM slave
    input  wire fcw_pkg::fcw_avs_req_t avs_req,
    output var  logic [31:0]           avs_readdata,
    output var  logic                  avs_waitrequest,
    // Strap pins and shared pin
    input  wire logic [4:0]            freq_strap,
    input  wire logic                  pin_in,
    output var  logic                  system_reset_out_n,
    output var  logic                  pin_oe_n,
    output var  logic                  pci_clock_halt_n,
    // Frequency in force
    output var  fcw_pkg::fcw_freq_t    active_freq
);
    import fcw_pkg::*;

    // Bus state
    logic            wait_ff, nxt_wait;                     // Waitrequest, high when idle
    logic [31:0]     rdata_ff, nxt_rdata;                   // Registered read data
    // Configuration state
    fcw_ctrl_t       ctrl_ff, nxt_ctrl;                     // Control byte
    logic            alarm_ff, nxt_alarm;                   // timeout_alarm_flag
    fcw_freq_t       sw_cur_ff, nxt_sw_cur;                 // Last software setting
    fcw_freq_t       sw_prev_ff, nxt_sw_prev;               // Setting before the last one
    logic [6:0]      pend_n_ff, nxt_pend_n;                 // N waiting for its R
    fcw_freq_t       active_ff, nxt_active;                 // Frequency in force
    logic [BOOT_W-1:0] boot_ff, nxt_boot;                   // Strap load after reset
    // Timer and pin state
    fcw_state_t      state_ff, nxt_state;
    logic [TICK_W-1:0] tick_ff, nxt_tick;                   // Cycles within a second
    logic [3:0]      sec_ff, nxt_sec;                       // Whole seconds elapsed
    logic            again_ff, nxt_again;                   // An expiry already happened
    logic [PULSE_W-1:0] pulse_ff, nxt_pulse;                // Reset pulse cycles left
    logic            rst_n_ff, nxt_rst_n;                   // Shared pin output value
    logic            oe_n_ff, nxt_oe_n;                     // Shared pin enable
    logic            halt_n_ff, nxt_halt_n;                 // Clock halt request seen
    // Synchronisers
    logic [4:0]      strap_s1_ff, strap_s2_ff;
    logic            pin_s1_ff, pin_s2_ff;

    // Decoded strobes
    logic            req_v, wr_ok, wr_ctrl, wr_fsel, wr_divr, freq_chg;
    logic            clear_to, tick_last, expire;
    fcw_freq_t       req_freq;

    // Strobes shared by both groups
    always_comb begin
        req_v     = avs_req.read | avs_req.write;
        wr_ok     = avs_req.write & ~wait_ff & avs_req.byteenable[0];
        wr_ctrl   = wr_ok & (avs_req.address == ADDR_CTRL);
        wr_fsel   = wr_ok & (avs_req.address == ADDR_FSEL);
        wr_divr   = wr_ok & (avs_req.address == ADDR_DIVR);
        freq_chg  = wr_fsel | wr_divr;
        clear_to  = wr_ctrl & (avs_req.writedata[CTRL_TO_LSB +: 4] == TO_OFF);
        tick_last = (tick_ff == TICK_W'(SEC_CYCLES_P - 1));
        // A code of n expires after n whole seconds
        expire    = (state_ff == FCW_RUN) & tick_last
                    & (4'(sec_ff + 4'h1) == ctrl_ff.timeout);
        // The byte just written forms the new setting with the stored other half
        req_freq  = sw_cur_ff;
        if (wr_fsel) begin
            req_freq.freq_sel = avs_req.writedata[4:0];
        end else begin
            req_freq.div_n = pend_n_ff;
            req_freq.div_r = avs_req.writedata[7:0];
        end
    end

    // Bus next state: one wait cycle, then the access completes
    always_comb begin
        nxt_wait  = 1'b1;
        nxt_rdata = rdata_ff;
        if (req_v && wait_ff) begin
            nxt_wait = 1'b0;
            if (avs_req.read) begin
                unique case (avs_req.address)
                    ADDR_CTRL: nxt_rdata = {24'h000000, ctrl_ff.pin_sel, ctrl_ff.revert,
                                            1'b0, alarm_ff, ctrl_ff.timeout};
                    ADDR_FSEL: nxt_rdata = {27'h0000000, sw_cur_ff.freq_sel};
                    ADDR_DIVN: nxt_rdata = {25'h0000000, pend_n_ff};
                    ADDR_DIVR: nxt_rdata = {24'h000000, sw_cur_ff.div_r};
                    ADDR_STAT: nxt_rdata = {18'h00000, strap_s2_ff, again_ff,
                                            state_ff == FCW_RUN, 2'h0, active_ff.freq_sel};
                    default:   nxt_rdata = 32'h00000000;               // Unmapped reads zero
                endcase
            end
        end
    end

    // Configuration next state
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_alarm   = alarm_ff;
        nxt_sw_cur  = sw_cur_ff;
        nxt_sw_prev = sw_prev_ff;
        nxt_pend_n  = pend_n_ff;
        nxt_active  = active_ff;
        nxt_boot    = boot_ff;
        // Strap is caught once the synchroniser has filled
        if (boot_ff != {BOOT_W{1'b1}}) begin
            nxt_boot = BOOT_W'(boot_ff + 1'b1);
            if (boot_ff == BOOT_W'(2)) begin
                nxt_active.freq_sel = strap_s2_ff;
            end
        end
        // Control byte, alarm bit is read only
        if (wr_ctrl) begin
            nxt_ctrl.timeout = avs_req.writedata[CTRL_TO_LSB +: 4];
            nxt_ctrl.revert  = avs_req.writedata[CTRL_REVERT_BIT];
            nxt_ctrl.pin_sel = avs_req.writedata[CTRL_PINSEL_BIT];
        end
        if (wr_ok && avs_req.address == ADDR_DIVN) begin
            nxt_pend_n = avs_req.writedata[6:0];
        end
        // New setting takes effect at once, timer follows later
        if (freq_chg) begin
            nxt_sw_prev = sw_cur_ff;
            nxt_sw_cur  = req_freq;
            nxt_active  = req_freq;
        end
        // From the second expiry on, fall back to the chosen frequency
        if (expire && again_ff) begin
            if (ctrl_ff.revert) begin
                nxt_active = sw_prev_ff;
            end else begin
                nxt_active          = '0;
                nxt_active.freq_sel = strap_s2_ff;
            end
        end
        // Expiry sets the alarm and wins over a clear in the same cycle
        if (expire) begin
            nxt_alarm = 1'b1;
        end else if (clear_to) begin
            nxt_alarm = 1'b0;
        end
    end

    // Timer and pin next state
    always_comb begin
        nxt_state = state_ff;
        nxt_tick  = tick_ff;
        nxt_sec   = sec_ff;
        nxt_again = again_ff;
        nxt_pulse = pulse_ff;
        unique case (state_ff)
            FCW_IDLE: begin
                // Only an armed timeout watches a frequency change
                if (freq_chg && ctrl_ff.timeout != TO_OFF) begin
                    nxt_state = FCW_ARM;
                    nxt_again = 1'b0;
                end
            end
            FCW_ARM: begin
                // New frequency is already in force here
                nxt_state = FCW_RUN;
                nxt_tick  = '0;
                nxt_sec   = '0;
            end
            FCW_RUN: begin
                if (expire) begin
                    nxt_tick  = '0;
                    nxt_sec   = '0;
                    nxt_again = 1'b1;
                end else if (tick_last) begin
                    nxt_tick = '0;
                    nxt_sec  = 4'(sec_ff + 4'h1);
                end else begin
                    nxt_tick = TICK_W'(tick_ff + 1'b1);
                end
                if (freq_chg) begin
                    nxt_state = FCW_ARM;
                    nxt_again = 1'b0;
                end
            end
            default: nxt_state = FCW_IDLE;
        endcase
        // Clearing the timeout stops the timer and keeps the frequency
        if (clear_to) begin
            nxt_state = FCW_IDLE;
            nxt_tick  = '0;
            nxt_sec   = '0;
        end
        // Reset pulse of fixed length
        if (expire) begin
            nxt_pulse = PULSE_W'(RST_PULSE_CYC);
        end else if (pulse_ff != '0) begin
            nxt_pulse = PULSE_W'(pulse_ff - 1'b1);
        end
        // Shared pin: reset output or halt input
        nxt_oe_n   = nxt_ctrl.pin_sel;
        nxt_rst_n  = nxt_ctrl.pin_sel | (nxt_pulse == '0);
        nxt_halt_n = ~nxt_ctrl.pin_sel | pin_s2_ff;
    end

    // Registers
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_ff     <= 1'b1;
            rdata_ff    <= 32'h00000000;
            ctrl_ff     <= '{pin_sel: PINSEL_RST, revert: 1'b0, timeout: TO_OFF};
            alarm_ff    <= 1'b0;
            sw_cur_ff   <= '0;
            sw_prev_ff  <= '0;
            pend_n_ff   <= 7'h00;
            active_ff   <= '0;
            boot_ff     <= '0;
            state_ff    <= FCW_IDLE;
            tick_ff     <= '0;
            sec_ff      <= 4'h0;
            again_ff    <= 1'b0;
            pulse_ff    <= '0;
            rst_n_ff    <= 1'b1;
            oe_n_ff     <= 1'b1;
            halt_n_ff   <= 1'b1;
            strap_s1_ff <= 5'h00;
            strap_s2_ff <= 5'h00;
            pin_s1_ff   <= 1'b1;
            pin_s2_ff   <= 1'b1;
        end else if (ce) begin
            wait_ff     <= nxt_wait;
            rdata_ff    <= nxt_rdata;
            ctrl_ff     <= nxt_ctrl;
            alarm_ff    <= nxt_alarm;
            sw_cur_ff   <= nxt_sw_cur;
            sw_prev_ff  <= nxt_sw_prev;
            pend_n_ff   <= nxt_pend_n;
            active_ff   <= nxt_active;
            boot_ff     <= nxt_boot;
            state_ff    <= nxt_state;
            tick_ff     <= nxt_tick;
            sec_ff      <= nxt_sec;
            again_ff    <= nxt_again;
            pulse_ff    <= nxt_pulse;
            rst_n_ff    <= nxt_rst_n;
            oe_n_ff     <= nxt_oe_n;
            halt_n_ff   <= nxt_halt_n;
            strap_s1_ff <= freq_strap;
            strap_s2_ff <= strap_s1_ff;
            pin_s1_ff   <= pin_in;
            pin_s2_ff   <= pin_s1_ff;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata       = rdata_ff;
    assign avs_waitrequest    = wait_ff;
    assign system_reset_out_n = rst_n_ff;
    assign pin_oe_n           = oe_n_ff;
    assign pci_clock_halt_n   = halt_n_ff;
    assign active_freq        = active_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || !ce);

    sequence s_expire_second;
        expire && again_ff;
    endsequence
    sequence s_pulse_on;
        !rst_n_ff && !oe_n_ff;
    endsequence

    chk_change_then_start: assert property (
        (freq_chg && ctrl_ff.timeout != TO_OFF && ce) |=> (active_ff == $past(req_freq))
        && state_ff == FCW_ARM ##1 state_ff == FCW_RUN && tick_ff == '0)
        else $error("timer did not start after the new frequency");
    chk_expiry_alarm: assert property (
        (expire && !ctrl_ff.pin_sel && !nxt_ctrl.pin_sel) |=> alarm_ff ##0 s_pulse_on)
        else $error("expiry without alarm or reset pulse");
    chk_pulse_width: assert property (
        $fell(rst_n_ff) |-> !rst_n_ff [*8])
        else $error("reset pulse too short");
    chk_fallback_strap: assert property (
        (s_expire_second and !ctrl_ff.revert) |=> active_ff.freq_sel == $past(strap_s2_ff))
        else $error("strap frequency not restored");
    chk_fallback_prev: assert property (
        (s_expire_second and ctrl_ff.revert) |=> active_ff == $past(sw_prev_ff))
        else $error("earlier software frequency not restored");
    chk_restart_timer: assert property (
        (expire && !clear_to && !freq_chg) |=> state_ff == FCW_RUN && tick_ff == '0
        && sec_ff == 4'h0 && again_ff)
        else $error("timer not restarted after expiry");
    chk_clear_stops: assert property (
        (clear_to && !expire) |=> !alarm_ff && state_ff == FCW_IDLE
        && active_ff == $past(active_ff) ##1 rst_n_ff || $past(pulse_ff) != '0)
        else $error("clearing the timeout did not stop the watchdog");
    chk_expiry_seconds: assert property (
        expire |-> ctrl_ff.timeout != TO_OFF && sec_ff == 4'(ctrl_ff.timeout - 4'h1))
        else $error("expiry at the wrong second");
    chk_pin_select: assert property (
        ctrl_ff.pin_sel |=> oe_n_ff || $past(wr_ctrl))
        else $error("shared pin driven while selected as input");
endmodule : fcw_top
`default_nettype wire

// *** core/fcw_pkg.sv ***
// Shared constants, register map and carrier types of the frequency-change watchdog
package fcw_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS  = 50;                     // 20 MHz reference clock
    localparam int SECOND_NS      = 1_000_000_000;          // One watchdog second
    localparam int SEC_CYCLES     = SECOND_NS / CLK_PERIOD_NS;
    localparam int RST_PULSE_NS   = 1000;                   // Width of a system reset pulse
    localparam int RST_PULSE_CYC  = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W         = 25;                     // Width of the sub-second counter
    localparam int PULSE_W        = 5;                      // Width of the pulse counter
    localparam int BOOT_W         = 2;                      // Width of the strap load counter

    // Register byte addresses
    localparam logic [4:0] ADDR_CTRL  = 5'h00;              // Watchdog control byte
    localparam logic [4:0] ADDR_FSEL  = 5'h04;              // Frequency select byte
    localparam logic [4:0] ADDR_DIVN  = 5'h08;              // Divider N byte
    localparam logic [4:0] ADDR_DIVR  = 5'h0C;              // Divider R byte, completes the pair
    localparam logic [4:0] ADDR_STAT  = 5'h10;              // Status word

    // Control byte fields
    localparam int CTRL_TO_LSB     = 0;                     // timeout_seconds_select, 4 bits
    localparam int CTRL_ALARM_BIT  = 4;                     // timeout_alarm_flag
    localparam int CTRL_REVERT_BIT = 6;                     // Fallback choice
    localparam int CTRL_PINSEL_BIT = 7;                     // Shared pin function
    localparam logic [3:0] TO_OFF  = 4'h0;                  // Watchdog disabled
    localparam logic       PINSEL_RST = 1'b1;               // Pin starts as clock halt input

    // Status word fields and the divider R source bit
    localparam int STAT_RUN_BIT    = 7;                     // Timer running
    localparam int STAT_AGAIN_BIT  = 8;                     // At least one expiry seen
    localparam int STAT_STRAP_LSB  = 9;                     // Synchronised strap, 5 bits
    localparam int DIVR_MUX_BIT    = 0;                     // Divider source select

    // Frequency setting carried as one unit
    typedef struct packed {
        logic [4:0] freq_sel;                               // Frequency select code
        logic [6:0] div_n;                                  // Divider N
        logic [7:0] div_r;                                  // Divider R and source select
    } fcw_freq_t;

    // Control byte contents
    typedef struct packed {
        logic       pin_sel;                                // 0 = reset output, 1 = halt input
        logic       revert;                                 // 0 = strap, 1 = earlier software
        logic [3:0] timeout;                                // Seconds, 0 = off
    } fcw_ctrl_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } fcw_avs_req_t;

    // Watchdog timer state
    typedef enum logic [1:0] {
        FCW_IDLE = 2'b00,
        FCW_ARM  = 2'b01,
        FCW_RUN  = 2'b11
    } fcw_state_t;
endpackage : fcw_pkg

// *** testbench/fcw_host_model.sv ***
// Host-side model: bus master transfers and firmware sequences for the watchdog
`timescale 1ns/1ps
`default_nettype none
module fcw_host_model (
    // Clock
    input  wire logic                  clk,
    // Avalon-MM master side
    output var  fcw_pkg::fcw_avs_req_t avs_req,
    input  wire logic [31:0]           avs_readdata,
    input  wire logic                  avs_waitrequest
);
    import fcw_pkg::*;

    // Bus idle until the first transfer
    initial begin
        avs_req = '0;
    end

    // One transfer: drive just after an edge, hold until waitrequest is sampled low
    task automatic bus_xfer(input logic rd, input logic [4:0] addr, input logic [31:0] wdata,
                            input logic [3:0] be, output logic [31:0] rdata);
        fcw_avs_req_t req;
        req = '0;
        req.read = rd;
        req.write = ~rd;
        req.address = addr;
        req.byteenable = be;
        req.writedata = wdata;
        @(posedge clk);
        avs_req <= req;
        @(posedge clk);
        // Wait for the slave; only the bench watchdog ends a hang
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rdata = avs_readdata;
        avs_req <= '0;
    endtask : bus_xfer

    // Register write with a chosen byte enable
    task automatic write_reg(input logic [4:0] addr, input logic [31:0] data,
                             input logic [3:0] be);
        logic [31:0] dummy;
        bus_xfer(1'b0, addr, data, be, dummy);
    endtask : write_reg

    // Register read
    task automatic read_reg(input logic [4:0] addr, output logic [31:0] data);
        bus_xfer(1'b1, addr, 32'h0000_0000, 4'hF, data);
    endtask : read_reg

    // Firmware: arm the timeout first, then ask for the new frequency
    task automatic change_freq_armed(input logic [7:0] ctrl, input logic [4:0] fsel);
        write_reg(ADDR_CTRL, {24'h00_0000, ctrl}, 4'hF);
        write_reg(ADDR_FSEL, {27'h000_0000, fsel}, 4'hF);
    endtask : change_freq_armed

    // Firmware: declare the new frequency good by clearing the timeout
    task automatic clear_timeout(input logic [7:0] ctrl);
        write_reg(ADDR_CTRL, {24'h00_0000, ctrl[7:4], TO_OFF}, 4'hF);
    endtask : clear_timeout
endmodule : fcw_host_model
`default_nettype wire

// *** testbench/tb_fcw_top.sv ***
// Self-checking testbench of the frequency-change watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_fcw_top;
    import fcw_pkg::*;
    localparam int SECP  = 50;                 // Shortened watchdog second
    localparam int PULSE = RST_PULSE_CYC;      // Reset pulse width in cycles
    logic         clk, srst, ce, pin_in, link_en, saw0, saw1;
    logic [4:0]   freq_strap, fa, fb;
    logic [3:0]   lcnt, tsel;
    logic [31:0]  avs_readdata, rd;
    logic         avs_waitrequest, system_reset_out_n, pin_oe_n, pci_clock_halt_n;
    logic [7:0]   ctrl, dn, dr;
    fcw_avs_req_t avs_req;
    fcw_freq_t    active_freq, exp_f;
    int           failures, cmp_count, seed, dly, wid;

    // Device under test with a short second
    fcw_top #(.SEC_CYCLES_P(SECP)) dut_u (
        .clk(clk), .srst(srst), .ce(ce), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .freq_strap(freq_strap), .pin_in(pin_in),
        .system_reset_out_n(system_reset_out_n), .pin_oe_n(pin_oe_n),
        .pci_clock_halt_n(pci_clock_halt_n), .active_freq(active_freq));

    // Host controller and firmware
    fcw_host_model host_u (
        .clk(clk), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // 20 MHz clock
    always #25 clk = ~clk;

    // Link clock of 400 ns on the shared pin input, idle high when off
    always @(posedge clk) begin
        lcnt <= lcnt + 4'h1;
        pin_in <= link_en ? lcnt[2] : 1'b1;
        if (pci_clock_halt_n === 1'b0) saw0 <= 1'b1;
        if (pci_clock_halt_n === 1'b1) saw1 <= 1'b1;
    end

    // Value comparison
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    // Cycle-count comparison against a window
    task automatic check_span(input string name, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            failures++;
            $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : check_span

    // Cycles until the reset pulse starts (bounded), then its width
    task automatic wait_pulse(input int lim);
        dly = 0;
        wid = 0;
        while (system_reset_out_n !== 1'b0 && dly < lim) begin
            @(posedge clk);
            #1 dly++;
        end
        while (system_reset_out_n === 1'b0 && wid < 100) begin
            @(posedge clk);
            #1 wid++;
        end
    endtask : wait_pulse

    // Frequency expected after a fallback: strap with cleared dividers, or the earlier setting
    function automatic fcw_freq_t fallback_freq(input logic rv, input logic [4:0] strap,
                                                input fcw_freq_t prev);
        if (rv) begin
            fallback_freq = prev;
        end else begin
            fallback_freq = '{freq_sel: strap, div_n: 7'h00, div_r: 8'h00};
        end
    endfunction : fallback_freq

    // Verdict and end of run
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // Hang guard, well beyond the expected run
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        finish_test();
    end

    // Main sequence
    initial begin
        seed = 79736;
        clk = 1'b0;
        srst = 1'b1;
        ce = 1'b1;
        pin_in = 1'b1;
        link_en = 1'b0;
        lcnt = 4'h0;
        saw0 = 1'b0;
        saw1 = 1'b0;
        failures = 0;
        cmp_count = 0;
        freq_strap = 5'($random(seed));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1 check_val("idle waitrequest", 32'h1, {31'h0, avs_waitrequest});
        check_val("idle reset out", 32'h1, {31'h0, system_reset_out_n});
        repeat (4) @(posedge clk);
        #1 check_val("strap freq", {27'h0, freq_strap}, {27'h0, active_freq.freq_sel});
        host_u.read_reg(ADDR_CTRL, rd);
        check_val("ctrl reset", 32'h80, rd);
        host_u.read_reg(ADDR_STAT, rd);
        check_val("stat strap", {27'h0, freq_strap}, {27'h0, rd[13:9]});
        host_u.read_reg(5'h14, rd);
        check_val("unmapped read", 32'h0, rd);
        host_u.write_reg(ADDR_CTRL, 32'h01, 4'hE);
        host_u.read_reg(ADDR_CTRL, rd);
        check_val("masked write", 32'h80, rd);
        // Shared pin as halt input, then as reset output
        link_en <= 1'b1;
        saw0 <= 1'b0;
        saw1 <= 1'b0;
        repeat (40) @(posedge clk);
        #1 check_val("halt follows pin", 32'h3, {30'h0, saw0, saw1});
        check_val("pin input oe", 32'h1, {31'h0, pin_oe_n});
        host_u.write_reg(ADDR_CTRL, 32'h00, 4'hF);
        // One edge later the halt output is settled, so the flag clear cannot race it
        @(posedge clk);
        saw0 <= 1'b0;
        repeat (40) @(posedge clk);
        #1 check_val("halt held", 32'h0, {31'h0, saw0});
        check_val("pin output oe", 32'h0, {31'h0, pin_oe_n});
        link_en <= 1'b0;
        // Divider pair applies only on its second byte
        dn = {1'b0, 7'($random(seed))};
        dr = 8'($random(seed));
        host_u.write_reg(ADDR_DIVN, {24'h0, dn}, 4'hF);
        #1 check_val("div n held", 32'h0, {25'h0, active_freq.div_n});
        host_u.write_reg(ADDR_DIVR, {24'h0, dr}, 4'hF);
        #1 check_val("div pair", {17'h0, dn[6:0], dr},
                     {17'h0, active_freq.div_n, active_freq.div_r});
        host_u.read_reg(ADDR_DIVN, rd);
        check_val("div n readback", {24'h0, dn}, rd);
        // Clear before expiry: no pulse, new frequency kept
        fb = freq_strap ^ 5'h1F;
        host_u.change_freq_armed(8'h02, fb);
        repeat (60) @(posedge clk);
        host_u.clear_timeout(8'h02);
        wait_pulse(150);
        check_span("no pulse after clear", 150, 150, dly);
        check_val("kept freq", {27'h0, fb}, {27'h0, active_freq.freq_sel});
        host_u.read_reg(ADDR_FSEL, rd);
        check_val("fsel readback", {27'h0, fb}, rd);
        // Repeated expiries with each fallback choice
        for (int rv = 0; rv < 2; rv++) begin
            tsel = 4'(1 + ($unsigned($random(seed)) % 2));
            ctrl = {1'b0, rv[0], 2'b00, tsel};
            fa = {~fb[4], 4'($random(seed))};
            host_u.change_freq_armed(ctrl, fa);
            host_u.change_freq_armed(ctrl, fb);
            #1 check_val("new freq", {27'h0, fb}, {27'h0, active_freq.freq_sel});
            // Five frozen edges push the expiry back by five cycles
            @(posedge clk);
            ce <= 1'b0;
            repeat (5) @(posedge clk);
            ce <= 1'b1;
            wait_pulse(2000);
            check_span("first expiry", tsel * SECP, tsel * SECP + 4, dly);
            check_span("pulse width", PULSE, PULSE, wid);
            check_val("no fallback yet", {27'h0, fb}, {27'h0, active_freq.freq_sel});
            host_u.read_reg(ADDR_CTRL, rd);
            check_val("alarm set", {24'h0, ctrl | 8'h10}, rd);
            exp_f = fallback_freq(rv[0], freq_strap,
                                  '{freq_sel: fa, div_n: dn[6:0], div_r: dr});
            for (int k = 0; k < 2; k++) begin
                wait_pulse(2000);
                check_span("later expiry", tsel * SECP - PULSE - 6,
                           tsel * SECP - PULSE + 2, dly);
                check_span("pulse width", PULSE, PULSE, wid);
                check_val("fallback freq", {12'h0, exp_f}, {12'h0, active_freq});
            end
            host_u.clear_timeout(ctrl);
            host_u.read_reg(ADDR_CTRL, rd);
            check_val("alarm cleared", {24'h0, ctrl[7:4], 4'h0}, rd);
            wait_pulse(tsel * SECP + 20);
            check_span("timer stopped", tsel * SECP + 20, tsel * SECP + 20, dly);
        end
        finish_test();
    end
endmodule : tb_fcw_top
`default_nettype wire
